// [common/i2c_start_pkg.sv]
package i2c_start_pkg;
    // bus widths
    localparam int DATA_W = 32;
    localparam int REG_W = 8;
    localparam int APB_ADDR_W = 4;

    // register byte addresses
    localparam logic [7:0] OFS_CONTROL = 8'h00;
    localparam logic [7:0] OFS_FLAG = 8'h04;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h08;
    localparam logic [7:0] OFS_IRQ_MASK = 8'h0C;

    // i2c_control_zero fields
    localparam int CTL_STOP = 0;
    localparam int CTL_START = 1;
    localparam int CTL_ACK = 2;
    localparam int CTL_WREL = 5;
    localparam int CTL_EXIT = 6;
    localparam int CTL_UE = 7;

    // i2c_flag_register fields
    localparam int FLG_RSV = 0;
    localparam int FLG_BUSY = 1;
    localparam int FLG_MASTER = 2;
    localparam int FLG_FAIL = 7;

    // interrupt events
    localparam int EV_DONE = 0;
    localparam int EV_FAIL = 1;
    localparam int EV_ARB = 2;
    localparam int EV_W = 3;

    // reset values
    localparam logic [REG_W-1:0] CONTROL_RESET = 8'h00;
    localparam logic [REG_W-1:0] FLAG_RESET = 8'h00;
    localparam logic [EV_W-1:0] EVENT_RESET = 3'h0;

    // line timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int START_HOLD_NS = 4000;
    localparam int SCL_LOW_NS = 4700;
    localparam int RESTART_SETUP_NS = 4700;
    localparam int CNT_W = 8;
    localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
    localparam logic [CNT_W-1:0] HOLD_CYC = CNT_W'((START_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] LOW_CYC = CNT_W'((SCL_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [CNT_W-1:0] SETUP_CYC = CNT_W'((RESTART_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_HOLD,
        ST_WAIT,
        ST_XFER,
        ST_REL_SDA,
        ST_REL_SCL,
        ST_SETUP
    } start_state_t;
endpackage : i2c_start_pkg

// [common/line_status_if.sv]
interface line_status_if;
    logic scl;
    logic sda;
    logic busy;
    logic start_seen;
    logic stop_seen;
    modport mon (output scl, output sda, output busy, output start_seen, output stop_seen);
    modport ctl (input scl, input sda, input busy, input start_seen, input stop_seen);
endinterface : line_status_if

// [rtl/i2c_line_monitor.sv]
module i2c_line_monitor (
    // clock, reset, enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // bus pins
    input wire logic scl_in,
    input wire logic sda_in,
    // decoded line state
    line_status_if.mon ls
);
    import i2c_start_pkg::*;

    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic scl_q;
    logic sda_q;
    logic busy;
    logic start_seen;
    logic stop_seen;
    logic [1:0] next_scl_sync;
    logic [1:0] next_sda_sync;
    logic next_busy;
    logic next_start_seen;
    logic next_stop_seen;

    assign ls.scl = scl_q;
    assign ls.sda = sda_q;
    assign ls.busy = busy;
    assign ls.start_seen = start_seen;
    assign ls.stop_seen = stop_seen;

    // edge logic reads only the second stage and its delayed copy
    always_comb begin
        next_scl_sync = {scl_sync[0], scl_in};
        next_sda_sync = {sda_sync[0], sda_in};
        next_start_seen = scl_q && scl_sync[1] && sda_q && !sda_sync[1];
        next_stop_seen = scl_q && scl_sync[1] && !sda_q && sda_sync[1];
        next_busy = busy;
        if (next_start_seen) begin
            next_busy = 1'b1;
        end else if (next_stop_seen) begin
            next_busy = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            scl_sync <= '1;
            sda_sync <= '1;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            busy <= 1'b0;
            start_seen <= 1'b0;
            stop_seen <= 1'b0;
        end else if (ce) begin
            scl_sync <= next_scl_sync;
            sda_sync <= next_sda_sync;
            scl_q <= scl_sync[1];
            sda_q <= sda_sync[1];
            busy <= next_busy;
            start_seen <= next_start_seen;
            stop_seen <= next_stop_seen;
        end
    end

    AST_BUSY_ON_START: assert property (@(posedge clk) disable iff (!rst_n) ce && start_seen |=> busy)
        else $error("bus not busy after start");
    AST_BUSY_OFF_STOP: assert property (@(posedge clk) disable iff (!rst_n) ce && stop_seen |=> !busy)
        else $error("bus still busy after stop");
endmodule : i2c_line_monitor

// [rtl/i2c_start_condition_trigger.sv]
module i2c_start_condition_trigger #(
    parameter int ADDR_W = i2c_start_pkg::APB_ADDR_W
) (
    // clock, reset, enable
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [i2c_start_pkg::DATA_W-1:0] pwdata,
    output logic [i2c_start_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // neighbouring transfer logic
    input wire logic arb_lost,
    input wire logic ack_window,
    input wire logic xfer_wait,
    output logic stop_request,
    output logic master,
    // interrupt
    output logic irq,
    // open-drain bus lines
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe_n,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe_n
);
    import i2c_start_pkg::*;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    line_status_if ls ();

    i2c_line_monitor u_monitor (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .ls(ls)
    );

    function automatic logic is_reg(input logic [ADDR_W-1:0] a, input logic [7:0] ofs);
        return a == ADDR_W'(ofs);
    endfunction : is_reg

    logic ue, ack_en, rsv_dis;
    logic next_ue, next_ack_en, next_rsv_dis, next_stop_request, next_pready, next_pslverr;
    logic [EV_W-1:0] irq_mask, next_irq_mask;
    logic [DATA_W-1:0] next_prdata;
    logic [REG_W-1:0] rd_byte, wd;
    logic mapped, acc, wr_now, wr_ctl, wr_flag, wr_status, wr_mask;

    start_state_t st, next_st;
    logic [CNT_W-1:0] cnt, next_cnt;
    logic trigger, next_trigger, start_failed, next_start_failed, next_master;
    logic [EV_W-1:0] irq_status, next_irq_status, ev;
    logic next_irq, next_scl_oe_n, next_sda_oe_n, lost;

    // a write lands at the completing access edge only
    assign acc = psel && penable && !pready;
    assign wr_now = psel && penable && pready && pwrite;
    assign wd = pwdata[REG_W-1:0];
    assign wr_ctl = wr_now && is_reg(paddr, OFS_CONTROL);
    assign wr_flag = wr_now && is_reg(paddr, OFS_FLAG);
    assign wr_status = wr_now && is_reg(paddr, OFS_IRQ_STATUS);
    assign wr_mask = wr_now && is_reg(paddr, OFS_IRQ_MASK);

    always_comb begin
        rd_byte = '0;
        mapped = 1'b1;
        if (is_reg(paddr, OFS_CONTROL)) begin
            rd_byte[CTL_UE] = ue;
            rd_byte[CTL_ACK] = ack_en;
            rd_byte[CTL_START] = 1'b0;
        end else if (is_reg(paddr, OFS_FLAG)) begin
            rd_byte[FLG_RSV] = rsv_dis;
            rd_byte[FLG_BUSY] = ls.busy;
            rd_byte[FLG_MASTER] = master;
            rd_byte[FLG_FAIL] = start_failed;
        end else if (is_reg(paddr, OFS_IRQ_STATUS)) begin
            rd_byte[EV_W-1:0] = irq_status;
        end else if (is_reg(paddr, OFS_IRQ_MASK)) begin
            rd_byte[EV_W-1:0] = irq_mask;
        end else begin
            mapped = 1'b0;
        end
        next_pready = acc;
        next_pslverr = acc && !mapped;
        next_prdata = (acc && !pwrite) ? DATA_W'(rd_byte) : '0;
        next_ue = ue;
        next_ack_en = ack_en;
        next_rsv_dis = rsv_dis;
        next_irq_mask = irq_mask;
        next_stop_request = 1'b0;
        if (wr_ctl) begin
            next_ue = wd[CTL_UE];
            next_ack_en = wd[CTL_ACK];
            next_stop_request = wd[CTL_STOP] && wd[CTL_UE] && ue;
        end
        if (wr_flag) begin
            next_rsv_dis = wd[FLG_RSV];
        end
        if (wr_mask) begin
            next_irq_mask = wd[EV_W-1:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ue <= CONTROL_RESET[CTL_UE];
            ack_en <= CONTROL_RESET[CTL_ACK];
            rsv_dis <= FLAG_RESET[FLG_RSV];
            irq_mask <= EVENT_RESET;
            stop_request <= CONTROL_RESET[CTL_STOP];
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else if (ce) begin
            ue <= next_ue;
            ack_en <= next_ack_en;
            rsv_dis <= next_rsv_dis;
            irq_mask <= next_irq_mask;
            stop_request <= next_stop_request;
            pready <= next_pready;
            pslverr <= next_pslverr;
            prdata <= next_prdata;
        end
    end

    // start sequencer, trigger and events
    always_comb begin
        next_st = st;
        next_cnt = cnt;
        next_trigger = trigger;
        next_start_failed = start_failed;
        next_master = master;
        ev = '0;
        lost = arb_lost;
        if (wr_flag && wd[FLG_FAIL]) begin
            next_start_failed = 1'b0;
        end
        if (wr_ctl && wd[CTL_START] && wd[CTL_UE] && ue) begin
            if (ls.busy && !master && rsv_dis) begin
                next_start_failed = 1'b1;
                ev[EV_FAIL] = 1'b1;
            end else begin
                next_trigger = 1'b1;
            end
        end
        unique case (st)
            ST_IDLE: begin
                if (trigger && !ls.busy) begin
                    next_st = ST_HOLD;
                    next_cnt = HOLD_CYC - CNT_ONE;
                end
            end
            ST_HOLD: begin
                if (cnt == '0) begin
                    next_st = ST_WAIT;
                    next_master = 1'b1;
                    next_trigger = 1'b0;
                    ev[EV_DONE] = 1'b1;
                end else begin
                    next_cnt = cnt - CNT_ONE;
                end
            end
            ST_WAIT: begin
                if (wr_ctl && wd[CTL_WREL]) begin
                    if (next_trigger) begin
                        next_st = ST_REL_SDA;
                        next_cnt = LOW_CYC - CNT_ONE;
                    end else begin
                        next_st = ST_XFER;
                    end
                end
            end
            ST_XFER: begin
                if (xfer_wait) begin
                    next_st = ST_WAIT;
                end
            end
            ST_REL_SDA: begin
                if (cnt == '0) begin
                    next_st = ST_REL_SCL;
                end else begin
                    next_cnt = cnt - CNT_ONE;
                end
            end
            ST_REL_SCL: begin
                if (!ls.sda) begin
                    lost = 1'b1;
                end else if (ls.scl) begin
                    next_st = ST_SETUP;
                    next_cnt = SETUP_CYC - CNT_ONE;
                end
            end
            ST_SETUP: begin
                if (!ls.sda) begin
                    lost = 1'b1;
                end else if (cnt == '0) begin
                    next_st = ST_HOLD;
                    next_cnt = HOLD_CYC - CNT_ONE;
                end else begin
                    next_cnt = cnt - CNT_ONE;
                end
            end
        endcase
        if (ls.stop_seen) begin
            next_master = 1'b0;
            if (st == ST_XFER) begin
                next_st = ST_IDLE;
            end
        end
        if (lost) begin
            next_st = ST_IDLE;
            next_master = 1'b0;
            next_trigger = 1'b0;
            ev[EV_ARB] = 1'b1;
        end
        if (!ue || (wr_ctl && (wd[CTL_EXIT] || !wd[CTL_UE]))) begin
            next_st = ST_IDLE;
            next_master = 1'b0;
            next_trigger = 1'b0;
        end
        next_sda_oe_n = 1'b1;
        next_scl_oe_n = 1'b1;
        if (next_st == ST_HOLD || next_st == ST_WAIT) begin
            next_sda_oe_n = 1'b0;
        end
        if (next_st == ST_XFER && ack_window && ack_en) begin
            next_sda_oe_n = 1'b0;
        end
        if (next_st == ST_WAIT || next_st == ST_REL_SDA) begin
            next_scl_oe_n = 1'b0;
        end
        // a new event beats a clear in the same cycle
        next_irq_status = (irq_status & ~(wr_status ? wd[EV_W-1:0] : EVENT_RESET)) | ev;
        next_irq = |(next_irq_status & next_irq_mask);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st <= ST_IDLE;
            cnt <= '0;
            trigger <= CONTROL_RESET[CTL_START];
            start_failed <= FLAG_RESET[FLG_FAIL];
            master <= 1'b0;
            irq_status <= EVENT_RESET;
            irq <= 1'b0;
            scl_oe_n <= 1'b1;
            sda_oe_n <= 1'b1;
            scl_out <= 1'b0;
            sda_out <= 1'b0;
        end else if (ce) begin
            st <= next_st;
            cnt <= next_cnt;
            trigger <= next_trigger;
            start_failed <= next_start_failed;
            master <= next_master;
            irq_status <= next_irq_status;
            irq <= next_irq;
            scl_oe_n <= next_scl_oe_n;
            sda_oe_n <= next_sda_oe_n;
            scl_out <= 1'b0;
            sda_out <= 1'b0;
        end
    end

    localparam int HOLD_LO = HOLD_CYC;
    localparam int HOLD_HI = HOLD_CYC + HOLD_CYC;

    sequence start_edge;
        $fell(sda_oe_n) && scl_oe_n && st == ST_HOLD;
    endsequence
    sequence busy_request;
        ce && trigger && ls.busy && st == ST_IDLE;
    endsequence
    sequence restart_request;
        ce && st == ST_WAIT && trigger && wr_ctl && wd[CTL_WREL] && ue && wd[CTL_UE] && !wd[CTL_EXIT] && !arb_lost;
    endsequence

    AST_START_SCL_HIGH: assert property (start_edge |-> (scl_oe_n && !sda_oe_n) [*8])
        else $error("scl pulled low too early after start");
    AST_START_HOLD: assert property (start_edge |-> ##[HOLD_LO:HOLD_HI] $fell(scl_oe_n))
        else $error("scl not pulled low after hold time");
    AST_RSV_WAIT: assert property (busy_request |=> sda_oe_n)
        else $error("start driven on a busy bus");
    AST_RSV_LAUNCH: assert property (ce && trigger && ue && !ls.busy && st == ST_IDLE && !arb_lost && !wr_ctl
        |=> !sda_oe_n && scl_oe_n)
        else $error("reserved start not launched");
    AST_RSV_FAIL: assert property (ce && wr_ctl && wd[CTL_START] && wd[CTL_UE] && ue && ls.busy && !master
        && rsv_dis |=> start_failed && !trigger && sda_oe_n)
        else $error("refused start not flagged");
    AST_RESTART: assert property (restart_request |=> sda_oe_n && !scl_oe_n && st == ST_REL_SDA)
        else $error("restart not begun after wait release");
    AST_DISABLED: assert property (ce && !ue |=> !trigger && sda_oe_n && scl_oe_n)
        else $error("disabled unit still triggers");
    AST_DONE_CLEAR: assert property (ce && st == ST_HOLD && cnt == '0 && ue && !wr_ctl && !arb_lost
        |=> !trigger && master && irq_status[EV_DONE])
        else $error("trigger not cleared after start");
    AST_READ_ZERO: assert property (pready && psel && !pwrite && is_reg(paddr, OFS_CONTROL)
        |-> !prdata[CTL_START])
        else $error("start trigger reads as one");
    AST_FLAG_MAP: assert property (pready && psel && !pwrite && is_reg(paddr, OFS_FLAG) && $past(ce)
        |-> prdata[FLG_FAIL] == $past(start_failed) && prdata[FLG_RSV] == $past(rsv_dis))
        else $error("flag register bits misplaced");
    AST_ACK: assert property (ce && st == ST_XFER && ue && ack_window && !xfer_wait && !arb_lost
        && !ls.stop_seen && !wr_ctl |=> sda_oe_n == !ack_en)
        else $error("acknowledge drive wrong");
endmodule : i2c_start_condition_trigger

// [tb/i2c_far_party.sv]
module i2c_far_party (
    // command from the bench
    input wire logic go,
    // open-drain drives, low pulls the line
    output logic scl_oe_n,
    output logic sda_oe_n
);
    timeunit 1ns;
    timeprecision 1ns;
    localparam int HALF_NS = 400;
    // keeps line changes off the block's sampling edges
    localparam int SKEW_NS = 30;
    initial begin
        scl_oe_n = 1'b1;
        sda_oe_n = 1'b1;
        forever begin
            @(posedge go);
            // start: data falls while clock is high, then clock is held low
            #SKEW_NS sda_oe_n = 1'b0;
            #HALF_NS scl_oe_n = 1'b0;
            @(negedge go);
            // stop: clock released first, data rises while clock is high
            #(HALF_NS + SKEW_NS) scl_oe_n = 1'b1;
            #HALF_NS sda_oe_n = 1'b1;
        end
    end
endmodule : i2c_far_party

// [tb/i2c_start_condition_trigger_tb.sv]
module i2c_start_condition_trigger_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import i2c_start_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [3:0] paddr = 4'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic [31:0] rd;
    logic pready, pslverr, er, stop_request, master, irq;
    logic scl_out, sda_out, scl_oe_n, sda_oe_n, p_scl_n, p_sda_n;
    logic arb_lost = 1'b0;
    logic ack_window = 1'b0;
    logic go = 1'b0;
    // open-drain lines with pull-ups
    wire logic scl = scl_oe_n & p_scl_n;
    wire logic sda = sda_oe_n & p_sda_n;
    int errors = 0;
    int cmp_count = 0;
    int n;

    i2c_start_condition_trigger u_dut (.clk(clk), .rst_n(rst_n), .ce(1'b1), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .arb_lost(arb_lost), .ack_window(ack_window), .xfer_wait(1'b0), .stop_request(stop_request),
        .master(master), .irq(irq), .scl_in(scl), .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n));
    i2c_far_party u_far (.go(go), .scl_oe_n(p_scl_n), .sda_oe_n(p_sda_n));

    initial begin
        forever #50 clk = ~clk;
    end

    task results;
        $display("errors=%0d compares=%0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : results

    task chk(input string s, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", s, e, g);
        end
    endtask : chk

    task hang(input string s);
        errors++;
        $display("BAD %s expected answer seen timeout", s);
        results();
    endtask : hang

    task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
        int k;
        k = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a[3:0];
        pwdata <= {24'h0, d};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) hang("pready");
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask : wr

    task rchk(input string s, input logic [7:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        chk(s, {24'h0, e}, rd);
    endtask : rchk

    task cyc(input int c);
        repeat (c) @(posedge clk);
    endtask : cyc

    task wait_sda;
        n = 0;
        while (sda_oe_n !== 1'b0) begin
            @(posedge clk);
            n++;
            if (n > 400) hang("sda_oe_n");
        end
    endtask : wait_sda

    // counts cycles in which the block pulls data low
    task quiet(input int c);
        int k;
        k = 0;
        repeat (c) begin
            @(posedge clk);
            if (sda_oe_n !== 1'b1) k++;
        end
        chk("no start", 32'h0, k);
    endtask : quiet

    task pbus(input logic v);
        @(posedge clk);
        go <= v;
        cyc(12);
    endtask : pbus

    task t_regs;
        rchk("control", OFS_CONTROL, CONTROL_RESET);
        rchk("flag", OFS_FLAG, FLAG_RESET);
        rchk("status", OFS_IRQ_STATUS, 8'h00);
        rchk("mask", OFS_IRQ_MASK, 8'h00);
        apb(1'b0, 8'h02, 8'h00);
        chk("pslverr", 32'h1, er);
        wr(OFS_CONTROL, 8'h84);
        wr(OFS_CONTROL, 8'h85);
        cyc(1);
        chk("stop pulse", 32'h1, stop_request);
        cyc(1);
        chk("stop pulse end", 32'h0, stop_request);
        rchk("control", OFS_CONTROL, 8'h84);
        wr(OFS_FLAG, 8'h01);
        rchk("flag", OFS_FLAG, 8'h01);
        wr(OFS_FLAG, 8'h00);
        $display("t_regs done");
    endtask : t_regs

    task t_start;
        wr(OFS_CONTROL, 8'h80);
        wr(OFS_CONTROL, 8'h82);
        wait_sda;
        chk("scl at start", 32'h1, scl);
        chk("sda at start", 32'h0, sda);
        chk("line outs", 32'h0, {scl_out, sda_out});
        n = 0;
        while (scl_oe_n !== 1'b0 && n < 200) begin
            @(posedge clk);
            n++;
        end
        chk("hold cycles", HOLD_CYC, n);
        rchk("control", OFS_CONTROL, 8'h80);
        rchk("flag", OFS_FLAG, 8'h06);
        chk("master", 32'h1, master);
        rchk("status", OFS_IRQ_STATUS, 8'h01);
        chk("irq masked", 32'h0, irq);
        wr(OFS_IRQ_MASK, 8'h01);
        cyc(2);
        chk("irq", 32'h1, irq);
        wr(OFS_IRQ_STATUS, 8'h01);
        cyc(2);
        chk("irq cleared", 32'h0, irq);
        $display("t_start done");
    endtask : t_start

    task t_restart;
        wr(OFS_CONTROL, 8'h82);
        cyc(5);
        chk("sda held in wait", 32'h0, sda_oe_n);
        wr(OFS_CONTROL, 8'hA0);
        cyc(3);
        chk("sda released", 32'h1, sda_oe_n);
        wait_sda;
        chk("scl at restart", 32'h1, scl);
        cyc(60);
        chk("master", 32'h1, master);
        $display("t_restart done");
    endtask : t_restart

    task t_exit;
        wr(OFS_CONTROL, 8'hC0);
        cyc(3);
        chk("master after exit", 32'h0, master);
        chk("scl free", 32'h1, scl_oe_n);
        chk("sda free", 32'h1, sda_oe_n);
        pbus(1'b1);
        pbus(1'b0);
        wr(OFS_IRQ_STATUS, 8'h07);
    endtask : t_exit

    task t_ack;
        wr(OFS_CONTROL, 8'hA4);
        cyc(3);
        chk("sda in transfer", 32'h1, sda_oe_n);
        ack_window <= 1'b1;
        cyc(3);
        chk("ack driven", 32'h0, sda_oe_n);
        wr(OFS_CONTROL, 8'h80);
        cyc(3);
        chk("ack off", 32'h1, sda_oe_n);
        ack_window <= 1'b0;
        t_exit();
        $display("t_ack done");
    endtask : t_ack

    task t_fail;
        pbus(1'b1);
        wr(OFS_FLAG, 8'h01);
        wr(OFS_CONTROL, 8'h82);
        cyc(2);
        rchk("flag", OFS_FLAG, 8'h83);
        rchk("status", OFS_IRQ_STATUS, 8'h02);
        wr(OFS_FLAG, 8'h81);
        rchk("flag", OFS_FLAG, 8'h03);
        go <= 1'b0;
        quiet(40);
        wr(OFS_FLAG, 8'h00);
        $display("t_fail done");
    endtask : t_fail

    task t_reserve;
        pbus(1'b1);
        wr(OFS_CONTROL, 8'h82);
        quiet(30);
        go <= 1'b0;
        wait_sda;
        chk("scl at reserved start", 32'h1, scl);
        cyc(50);
        chk("master", 32'h1, master);
        t_exit();
        $display("t_reserve done");
    endtask : t_reserve

    task t_clear;
        pbus(1'b1);
        wr(OFS_CONTROL, 8'h82);
        @(posedge clk);
        arb_lost <= 1'b1;
        @(posedge clk);
        arb_lost <= 1'b0;
        go <= 1'b0;
        quiet(40);
        pbus(1'b1);
        wr(OFS_CONTROL, 8'h82);
        wr(OFS_CONTROL, 8'h00);
        wr(OFS_CONTROL, 8'h02);
        go <= 1'b0;
        quiet(40);
        $display("t_clear done");
    endtask : t_clear

    initial begin
        repeat (3) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_start();
        t_restart();
        t_ack();
        t_fail();
        t_reserve();
        t_clear();
        results();
    end
endmodule : i2c_start_condition_trigger_tb
